// file: verilog/noa_map.svh
`ifndef NOA_MAP_SVH
`define NOA_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define NOA_ADDR_CONTROL    8'h00
`define NOA_ADDR_CLOCK_CTRL 8'h01
`define NOA_ADDR_INC_LOW    8'h02
`define NOA_ADDR_INC_HIGH   8'h03
`define NOA_ADDR_INC_UPPER  8'h04
`define NOA_ADDR_IRQ_FLAG   8'h05
`define NOA_ADDR_IRQ_ENABLE 8'h06

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define NOA_RESET_BYTE      8'h00
`define NOA_RESET_INC       20'h00000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NOA_CTRL_ENABLE_BIT 7
`define NOA_CTRL_OUT_BIT    5
`define NOA_CTRL_POL_BIT    4
`define NOA_CTRL_PFM_BIT    0
`define NOA_FLAG_OVF_BIT    0
`define NOA_IE_OVF_BIT      0
`define NOA_IE_PERIPH_BIT   6
`define NOA_IE_GLOBAL_BIT   7

// ----------------------------------------------------------------------
// Codes and write masks
// ----------------------------------------------------------------------
`define NOA_HFINT_CODE      4'h0
`define NOA_CTRL_WR_MASK    8'h91
`define NOA_CLK_WR_MASK     8'hef
`define NOA_IE_WR_MASK      8'hc1

`endif

// file: verilog/noa_pkg.sv
package noa_pkg;

	typedef struct packed {
		logic       module_enable;
		logic       rsv6;
		logic       output_state;
		logic       output_polarity;
		logic [2:0] rsv3_1;
		logic       pulse_mode_select;
	} noa_control_t;

	typedef struct packed {
		logic [2:0] pulse_width_select;
		logic       rsv4;
		logic [3:0] clock_source_select;
	} noa_clock_ctrl_t;

	typedef struct packed {
		logic       global_irq_enable;
		logic       peripheral_irq_enable;
		logic [4:0] rsv5_1;
		logic       overflow_irq_enable;
	} noa_irq_enable_t;

	typedef enum logic [1:0] {
		NOA_PF_IDLE   = 2'b01,
		NOA_PF_ACTIVE = 2'b10
	} noa_pf_state_t;

	typedef enum logic [2:0] {
		NOA_LD_IDLE   = 3'b001,
		NOA_LD_FIRST  = 3'b010,
		NOA_LD_SECOND = 3'b100
	} noa_load_state_t;

endpackage : noa_pkg

// file: verilog/noa_oscillator.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "noa_map.svh"

// Contract
// R01 - Each selected source edge adds the active increment to the accumulator.
// R02 - Increment is 20 bits in low, high and upper byte registers.
// R03 - Software writes upper and high before low while enabled.
// R04 - Low write while enabled loads buffers on second source edge.
// R05 - Increment registers are read/write, double-buffered by hidden buffers.
// R06 - While disabled, increment writes reach the buffers at once.
// R07 - Fixed-duty mode toggles output on every overflow.
// R08 - Control bit 0 clear selects fixed-duty, set selects pulse mode.
// R09 - Pulse mode: active on next source edge after overflow, for width.
// R10 - Pulse width field sits in clock control bits 7 to 5.
// R11 - Width is two to the field value source periods, 1 to 128.
// R12 - Width longer than overflow interval keeps the output active.
// R13 - Polarity bit 4 inverts the final output when set.
// R14 - Polarity change with interrupts enabled raises the interrupt flag.
// R15 - Final output feeds logic cells, waveform generator, timers, clock out.
// R16 - Every overflow sets the overflow interrupt flag.
// R17 - Interrupt event needs module, overflow, peripheral and global enables.
// R18 - Software clears the flag; hardware never clears it.
// R19 - Any reset clears every register to zero.
// R20 - Runs from its source clock, independent of system sleep.
// R21 - Enabled with internal fast oscillator selected keeps it alive in sleep.
// R22 - Control bit 5 is read-only and shows the present output.
// R23 - Control bit 7 enables the oscillator.
// R24 - Clock control bits 3 to 0 choose the source clock.
// R25 - Accumulator is 20 bits; its carry is the raw overflow.
// R26 - Accumulator keeps the sum modulo two to the twentieth.

module noa_oscillator #(
	parameter int NUM_SOURCES = 11
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [7:0]             addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   write_strobe,
	input  wire logic                   read_strobe,
	output logic      [7:0]             rdata,
	input  wire logic [NUM_SOURCES-1:0] source_clock,
	output logic                        oscillator_output,
	output logic                        overflow_irq_event,
	output logic                        high_freq_osc_hold
);

	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	if (NUM_SOURCES < 1 || NUM_SOURCES > 16) begin : g_bad_sources
		$error("NUM_SOURCES must lie in 1 to 16");
	end

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [7:0] width_periods(input logic [2:0] sel);
		width_periods = 8'h01 << sel;
	endfunction : width_periods

	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] target);
		addr_hit = (a == target);
	endfunction : addr_hit

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	noa_pkg::noa_control_t    control;
	noa_pkg::noa_clock_ctrl_t clock_ctrl;
	noa_pkg::noa_irq_enable_t irq_enable;
	noa_pkg::noa_pf_state_t   pf_state;
	noa_pkg::noa_pf_state_t   next_pf_state;
	noa_pkg::noa_load_state_t load_state;
	noa_pkg::noa_load_state_t next_load_state;

	logic [7:0]             increment_low;
	logic [7:0]             increment_high;
	logic [7:0]             increment_upper;
	logic [19:0]            increment_buffer;
	logic [19:0]            accumulator;
	logic                   overflow_irq_flag;
	logic                   fdc_toggle;
	logic                   carry_pending;
	logic [7:0]             width_count;
	logic [7:0]             next_width_count;
	logic [NUM_SOURCES-1:0] sync_1;
	logic [NUM_SOURCES-1:0] sync_2;
	logic [NUM_SOURCES-1:0] sync_3;
	logic [NUM_SOURCES-1:0] source_level;
	logic                   selected_prev;

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	wire wr_control  = write_strobe && addr_hit(addr, `NOA_ADDR_CONTROL);
	wire wr_clock    = write_strobe && addr_hit(addr, `NOA_ADDR_CLOCK_CTRL);
	wire wr_inc_low  = write_strobe && addr_hit(addr, `NOA_ADDR_INC_LOW);
	wire wr_inc_high = write_strobe && addr_hit(addr, `NOA_ADDR_INC_HIGH);
	wire wr_inc_up   = write_strobe && addr_hit(addr, `NOA_ADDR_INC_UPPER);
	wire wr_flag     = write_strobe && addr_hit(addr, `NOA_ADDR_IRQ_FLAG);
	wire wr_irq_en   = write_strobe && addr_hit(addr, `NOA_ADDR_IRQ_ENABLE);
	wire wr_any_inc  = wr_inc_low || wr_inc_high || wr_inc_up;

	wire       enabled  = control.module_enable;
	wire       pol      = control.output_polarity;
	wire       pfm      = control.pulse_mode_select;
	wire [2:0] pws      = clock_ctrl.pulse_width_select;
	wire [3:0] cks      = clock_ctrl.clock_source_select;

	wire [7:0] next_inc_low   = wr_inc_low  ? wdata : increment_low;
	wire [7:0] next_inc_high  = wr_inc_high ? wdata : increment_high;
	wire [7:0] next_inc_upper = wr_inc_up   ? wdata : increment_upper;
	wire [19:0] next_inc_word = {next_inc_upper[3:0], next_inc_high,
		next_inc_low};                                          // [R02]

	// ------------------------------------------------------------------
	// Source clock selection and edge detection
	// ------------------------------------------------------------------
	// A level counts only once the second and third stages agree;
	// while they differ the last accepted level holds.
	wire [NUM_SOURCES-1:0] stages_agree      = sync_2 ~^ sync_3;
	wire [NUM_SOURCES-1:0] next_source_level =
		(source_level & ~stages_agree) | (sync_3 & stages_agree);
	// Reserved codes select nothing, so the accumulator stands still.
	wire source_valid   = ({28'h0000000, cks} < NUM_SOURCES);         // [R24]
	wire selected_level = source_valid && source_level[cks];          // [R24]
	wire source_tick    = selected_level && !selected_prev;
	wire active_tick    = source_tick && enabled;                     // [R20]

	// ------------------------------------------------------------------
	// Adder
	// ------------------------------------------------------------------
	wire [20:0] sum         = {1'b0, accumulator} + {1'b0, increment_buffer};
	wire        carry_tick  = active_tick && sum[20];                 // [R25]

	// ------------------------------------------------------------------
	// Interrupt flag
	// ------------------------------------------------------------------
	wire irqs_open  = irq_enable.overflow_irq_enable &&
		irq_enable.peripheral_irq_enable && irq_enable.global_irq_enable;
	// A polarity flip is an output transition even while stopped.
	wire pol_change = wr_control &&
		(wdata[`NOA_CTRL_POL_BIT] != pol) && irqs_open;              // [R14]
	wire flag_set   = carry_tick || pol_change;                       // [R16]
	// Hardware set wins over a software clear in the same cycle.
	wire next_flag  = flag_set ? 1'b1 :
		(wr_flag ? wdata[`NOA_FLAG_OVF_BIT] : overflow_irq_flag);       // [R18]

	// ------------------------------------------------------------------
	// Pulse mode sequencing
	// ------------------------------------------------------------------
	// Width is counted in source ticks, not system clocks.
	always_comb begin
		next_pf_state    = pf_state;
		next_width_count = width_count;
		case (pf_state)
			noa_pkg::NOA_PF_IDLE: begin
				if (active_tick && carry_pending) begin                    // [R09]
					next_pf_state    = noa_pkg::NOA_PF_ACTIVE;
					next_width_count = width_periods(pws);                   // [R11]
				end
			end
			noa_pkg::NOA_PF_ACTIVE: begin
				if (active_tick && carry_pending) begin
					// A fresh overflow restarts the width: output holds.
					next_width_count = width_periods(pws);                   // [R12]
				end else if (active_tick && width_count <= 8'h01) begin
					next_pf_state    = noa_pkg::NOA_PF_IDLE;
					next_width_count = 8'h00;
				end else if (active_tick) begin
					next_width_count = width_count - 8'h01;
				end
			end
			default: begin
				next_pf_state    = noa_pkg::NOA_PF_IDLE;
				next_width_count = 8'h00;
			end
		endcase
		if (!enabled) begin
			next_pf_state    = noa_pkg::NOA_PF_IDLE;
			next_width_count = 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Increment buffer load sequencing
	// ------------------------------------------------------------------
	always_comb begin
		next_load_state = load_state;
		case (load_state)
			noa_pkg::NOA_LD_IDLE: begin
			end
			noa_pkg::NOA_LD_FIRST: begin
				if (source_tick) begin
					next_load_state = noa_pkg::NOA_LD_SECOND;
				end
			end
			noa_pkg::NOA_LD_SECOND: begin
				if (source_tick) begin
					next_load_state = noa_pkg::NOA_LD_IDLE;                  // [R04]
				end
			end
			default: begin
				next_load_state = noa_pkg::NOA_LD_IDLE;
			end
		endcase
		// Toggling the enable drops any pending delayed load.
		if (enabled && wr_inc_low) begin
			next_load_state = noa_pkg::NOA_LD_FIRST;                     // [R04]
		end else if (!enabled) begin
			next_load_state = noa_pkg::NOA_LD_IDLE;
		end
	end

	wire load_delayed = (load_state == noa_pkg::NOA_LD_SECOND) &&
		source_tick && enabled && !wr_inc_low;                          // [R04]
	wire load_now     = !enabled && wr_any_inc;                         // [R06]
	wire [19:0] next_buffer = load_now ? next_inc_word :
		(load_delayed ? next_inc_word : increment_buffer);              // [R05]

	// ------------------------------------------------------------------
	// Output path
	// ------------------------------------------------------------------
	// While stopped raw is 0, so the output shows the polarity.
	wire raw_output  = pfm ? (pf_state == noa_pkg::NOA_PF_ACTIVE)
		: fdc_toggle;                                                   // [R08]
	wire next_output = raw_output ^ pol;                              // [R13]

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	wire [7:0] control_view = {enabled, 1'b0, oscillator_output, pol,
		3'b000, pfm};                                                   // [R22]
	wire [7:0] read_value =
		addr_hit(addr, `NOA_ADDR_CONTROL)    ? control_view :
		addr_hit(addr, `NOA_ADDR_CLOCK_CTRL) ? clock_ctrl :
		addr_hit(addr, `NOA_ADDR_INC_LOW)    ? increment_low :
		addr_hit(addr, `NOA_ADDR_INC_HIGH)   ? increment_high :
		addr_hit(addr, `NOA_ADDR_INC_UPPER)  ? increment_upper :
		addr_hit(addr, `NOA_ADDR_IRQ_FLAG)   ? {7'h00, overflow_irq_flag} :
		addr_hit(addr, `NOA_ADDR_IRQ_ENABLE) ? irq_enable :
		`NOA_RESET_BYTE;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin                                                 // [R19]
			control         <= `NOA_RESET_BYTE;
			clock_ctrl      <= `NOA_RESET_BYTE;
			irq_enable      <= `NOA_RESET_BYTE;
			increment_low   <= `NOA_RESET_BYTE;
			increment_high  <= `NOA_RESET_BYTE;
			increment_upper <= `NOA_RESET_BYTE;
			rdata           <= `NOA_RESET_BYTE;
		end else begin
			// Masks keep reserved and read-only bits at zero.
			if (wr_control) begin
				control <= wdata & `NOA_CTRL_WR_MASK;                      // [R23]
			end
			if (wr_clock) begin
				clock_ctrl <= wdata & `NOA_CLK_WR_MASK;                    // [R10]
			end
			if (wr_irq_en) begin
				irq_enable <= wdata & `NOA_IE_WR_MASK;
			end
			increment_low   <= next_inc_low;
			increment_high  <= next_inc_high;
			increment_upper <= {4'h0, next_inc_upper[3:0]};
			// Read data stand one cycle only, then fall back to zero.
			rdata           <= read_strobe ? read_value : `NOA_RESET_BYTE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_1        <= '0;
			sync_2        <= '0;
			sync_3        <= '0;
			source_level  <= '0;
			selected_prev <= 1'b0;
		end else begin
			// Only the second stage reads the first one.
			sync_1        <= source_clock;
			sync_2        <= sync_1;
			sync_3        <= sync_2;
			source_level  <= next_source_level;
			selected_prev <= selected_level;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			increment_buffer <= `NOA_RESET_INC;
			accumulator      <= `NOA_RESET_INC;
			load_state       <= noa_pkg::NOA_LD_IDLE;
		end else begin
			increment_buffer <= next_buffer;
			load_state       <= next_load_state;
			// Holds while stopped; enabling resumes from the old phase.
			if (active_tick) begin
				accumulator <= sum[19:0];                                  // [R01] [R26]
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fdc_toggle    <= 1'b0;
			carry_pending <= 1'b0;
			pf_state      <= noa_pkg::NOA_PF_IDLE;
			width_count   <= 8'h00;
		end else begin
			pf_state    <= next_pf_state;
			width_count <= next_width_count;
			if (!enabled) begin
				fdc_toggle    <= 1'b0;
				carry_pending <= 1'b0;
			end else if (active_tick) begin
				fdc_toggle    <= fdc_toggle ^ sum[20];                     // [R07]
				carry_pending <= sum[20];                                  // [R09]
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow_irq_flag  <= 1'b0;
			oscillator_output  <= 1'b0;
			overflow_irq_event <= 1'b0;
			high_freq_osc_hold <= 1'b0;
		end else begin
			overflow_irq_flag  <= next_flag;
			// One output serves all internal consumers.
			oscillator_output  <= next_output;                           // [R15]
			overflow_irq_event <= next_flag && enabled && irqs_open;      // [R17]
			high_freq_osc_hold <= enabled &&
				(cks == `NOA_HFINT_CODE);                                   // [R21]
		end
	end

endmodule : noa_oscillator

// file: test/noa_osc_sva.sv
`timescale 1ns/1ps

module noa_osc_sva (
	input logic       clk,
	input logic       reset,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic       write_strobe,
	input logic       read_strobe,
	input logic [7:0] rdata,
	input logic       oscillator_output,
	input logic       overflow_irq_event,
	input logic       high_freq_osc_hold
);
	// ------------------------------------------------------------------
	// Shadow of the written control fields
	// ------------------------------------------------------------------
	logic       en_q;
	logic       pol_q;
	logic       ie_ok;
	logic [3:0] cks_q;
	logic       sel_d;
	logic [1:0] quiet;
	wire        sel  = en_q && (cks_q == 4'h0);
	wire        gate = en_q && ie_ok;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{en_q, pol_q, ie_ok, cks_q, sel_d} <= 8'h00;
		end else begin
			sel_d <= sel;
			if (write_strobe && addr == 8'h00) begin
				en_q  <= wdata[7];
				pol_q <= wdata[4];
			end
			if (write_strobe && addr == 8'h01)
				cks_q <= wdata[3:0];
			if (write_strobe && addr == 8'h06)
				ie_ok <= wdata[7] & wdata[6] & wdata[0];
		end
	end

	// Settling count after a control write; output lags by two clocks
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			quiet <= 2'h0;
		else if (write_strobe && addr == 8'h00)
			quiet <= 2'h0;
		else if (quiet != 2'h3)
			quiet <= quiet + 2'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	a_rdata_idle: assert property (
		!read_strobe |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (
		read_strobe && addr > 8'h06 |=> rdata == 8'h00)
		else $error("unmapped address read not zero");
	a_ctrl_reserved: assert property (
		read_strobe && addr == 8'h00 |=> (rdata & 8'h4e) == 8'h00)
		else $error("control reserved bits not zero");
	a_clk_reserved: assert property (
		read_strobe && addr == 8'h01 |=> !rdata[4])
		else $error("clock control bit 4 not zero");
	a_upper_reserved: assert property (
		read_strobe && addr == 8'h04 |=> rdata[7:4] == 4'h0)
		else $error("increment upper bits 7 to 4 not zero");
	a_ctrl_readback: assert property (
		read_strobe && addr == 8'h00 |=>
			rdata[7] == $past(en_q) && rdata[4] == $past(pol_q))
		else $error("control readback differs from write");
	a_irq_gate: assert property (
		overflow_irq_event |-> $past(gate))
		else $error("interrupt event without all enables");
	a_disabled_out: assert property (
		quiet == 2'h3 && !en_q |-> oscillator_output == pol_q)
		else $error("disabled output differs from polarity");
	a_hold_sel: assert property (
		high_freq_osc_hold == sel_d)
		else $error("fast oscillator hold wrong");
endmodule : noa_osc_sva

bind noa_oscillator noa_osc_sva u_sva (
	.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
	.write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
	.oscillator_output(oscillator_output),
	.overflow_irq_event(overflow_irq_event),
	.high_freq_osc_hold(high_freq_osc_hold)
);

// file: test/noa_source_model.sv
`timescale 1ns/1ps

module noa_source_model #(
	parameter int NUM_SOURCES = 11
) (
	input  logic [3:0]             sel,
	input  logic                   go,
	input  int                     pulses,
	input  logic                   oscillator_output,
	output logic [NUM_SOURCES-1:0] source_clock,
	output logic                   busy,
	output int                     rises
);
	// ------------------------------------------------------------------
	// Source burst and output consumer
	// ------------------------------------------------------------------
	initial begin
		source_clock = '0;
		busy         = 1'b0;
		rises        = 0;
	end

	// Consumer side only counts edges of the routed output
	always @(posedge oscillator_output) begin
		rises++;
	end

	// Phases of 40 ns keep each level above three system clocks;
	// the source stands low between bursts
	always @(posedge go) begin
		busy = 1'b1;
		repeat (pulses) begin
			source_clock[sel] = 1'b1;
			#40;
			source_clock[sel] = 1'b0;
			#40;
		end
		busy = 1'b0;
	end
endmodule : noa_source_model

// file: test/test_numeric_osc_accumulator.sv
`timescale 1ns/1ps

module test_numeric_osc_accumulator;
	logic        clk          = 1'b0;
	logic        reset        = 1'b1;
	logic        write_strobe = 1'b0;
	logic        read_strobe  = 1'b0;
	logic        go           = 1'b0;
	logic [7:0]  addr         = 8'h00;
	logic [7:0]  wdata        = 8'h00;
	logic [3:0]  sel          = 4'h0;
	logic [7:0]  rdata;
	logic [10:0] source_clock;
	logic        oscillator_output;
	logic        overflow_irq_event;
	logic        high_freq_osc_hold;
	logic        busy;
	int          pulses       = 0;
	int          rises;
	int          fails        = 0;
	int          comparisons  = 0;
	logic [2:0]  pws_tab [4]  = '{3'h0, 3'h1, 3'h3, 3'h7};
	int          exp_tab [4]  = '{3, 3, 1, 1};

	always #5 clk = ~clk;

	noa_oscillator DUT (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.rdata(rdata), .source_clock(source_clock),
		.oscillator_output(oscillator_output),
		.overflow_irq_event(overflow_irq_event),
		.high_freq_osc_hold(high_freq_osc_hold)
	);

	noa_source_model #(.NUM_SOURCES(11)) partner (
		.sel(sel), .go(go), .pulses(pulses),
		.oscillator_output(oscillator_output),
		.source_clock(source_clock), .busy(busy), .rises(rises)
	);

	// ------------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		addr         <= a;
		wdata        <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk);
		addr        <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1;
		chk($sformatf("register %0h", a), {24'h0, rdata}, {24'h0, exp});
	endtask : rd

	// Bursts n source ticks and counts rising edges of the output
	task automatic run(input int n, input int exp_rises);
		int base;
		base = rises;
		@(posedge clk);
		pulses <= n;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 3000 && busy === 1'b1; i++)
			@(posedge clk);
		// Synchroniser and output register latency
		repeat (20) @(posedge clk);
		chk("output rises", 32'(rises - base), 32'(exp_rises));
	endtask : run

	task automatic final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		#200us;
		fails++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd(8'(a), 8'h00);
		$display("test reset_values done");
		wr(8'h00, 8'h7f);
		rd(8'h00, 8'h31);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'hff);
		rd(8'h01, 8'hef);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h0f);
		wr(8'h03, 8'h5a);
		rd(8'h03, 8'h5a);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'hc1);
		wr(8'h06, 8'h00);
		wr(8'h09, 8'hff);
		rd(8'h09, 8'h00);
		$display("test register_access done");
		// Three overflows in four ticks checks the carried remainder
		wr(8'h01, 8'h00);
		wr(8'h04, 8'h0c);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h80);
		@(posedge clk);
		#1;
		chk("fast osc hold", 32'(high_freq_osc_hold), 32'h1);
		run(16, 6);
		rd(8'h05, 8'h01);
		wr(8'h00, 8'h00);
		wr(8'h05, 8'h00);
		rd(8'h05, 8'h00);
		$display("test fixed_duty done");
		wr(8'h04, 8'h04);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h00);
		sel <= 4'h3;
		for (int k = 0; k < 4; k++) begin
			wr(8'h01, {pws_tab[k], 5'h03});
			wr(8'h00, 8'h81);
			#1;
			chk("fast osc idle", 32'(high_freq_osc_hold), 32'h0);
			run(16, exp_tab[k]);
			wr(8'h00, 8'h00);
		end
		$display("test pulse_mode done");
		wr(8'h05, 8'h00);
		wr(8'h06, 8'hc1);
		wr(8'h00, 8'h10);
		rd(8'h05, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		chk("irq event disabled", 32'(overflow_irq_event), 32'h0);
		wr(8'h00, 8'h90);
		repeat (3) @(posedge clk);
		#1;
		chk("irq event enabled", 32'(overflow_irq_event), 32'h1);
		wr(8'h05, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		chk("irq event cleared", 32'(overflow_irq_event), 32'h0);
		wr(8'h06, 8'h00);
		wr(8'h00, 8'h00);
		wr(8'h05, 8'h00);
		$display("test interrupt done");
		wr(8'h04, 8'h00);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h80);
		wr(8'h04, 8'h08);
		run(4, 0);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h00);
		run(6, 1);
		$display("test buffered_load done");
		final_report();
	end
endmodule : test_numeric_osc_accumulator
